/* File: src/gtc_ctrl.sv */
// Pin function, test voltage source and level-shift control of the converter.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Eight pin functions 0..7 share the analog inputs from input three up to the common pin.
// - A set bit in the connect register attaches the pin function, a clear bit leaves the analog input.
// - A clear direction bit makes the pin an output, a set bit an input.
// - Writing the value register sets output levels and reading it returns sampled input levels.
// - The value bit of an output pin reads as zero.
// - The test source has positive and negative channels, each set by its own code register.
// - The positive channel feeds both positive input muxes, the negative channel both negative ones.
// - Two route bits put the positive channel on input six and the negative channel on input seven.
// - Code zero gives the mid-supply level, a ratio of one half.
// - Codes 01h-09h raise and 11h-19h lower the level by mirrored steps from 0.0015625 to 0.4.
// - An optional level shift at mid supply can be put on the common input pin.
module gtc_ctrl #(
    parameter int NPINS = gtc_pkg::NUM_PINS,
    parameter int SETTLE_C01 = gtc_pkg::LS_CYC_C01,
    parameter int SETTLE_C1 = gtc_pkg::LS_CYC_C1,
    parameter int SETTLE_C10 = gtc_pkg::LS_CYC_C10
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic [gtc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [gtc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [gtc_pkg::DATA_W-1:0] rdata_o,
    input wire logic [gtc_pkg::DATA_W-1:0] pin_in_i,
    output logic [gtc_pkg::DATA_W-1:0] pin_out_o,
    output logic [gtc_pkg::DATA_W-1:0] pin_oe_o,
    output logic [gtc_pkg::DATA_W-1:0] pin_connect_o,
    output gtc_pkg::gtc_test_chan_t test_pos_o,
    output gtc_pkg::gtc_test_chan_t test_neg_o,
    output logic test_pos_to_mux_o,
    output logic test_neg_to_mux_o,
    output logic test_pos_pin_route_o,
    output logic test_neg_pin_route_o,
    output logic level_shift_en_o,
    output logic level_shift_ready_o
);
    import gtc_pkg::*;

    initial begin
        if (NPINS != NUM_PINS) begin
            $error("gtc_ctrl serves exactly eight shared pins");
        end
        if (SETTLE_C01 < 1 || SETTLE_C1 < 1 || SETTLE_C10 < 1) begin
            $error("gtc_ctrl settle counts must be at least one cycle");
        end
        // Any of the three loads may be the longest, so each is checked.
        if (SETTLE_C01 >= (1 << LS_CNT_W) || SETTLE_C1 >= (1 << LS_CNT_W)
            || SETTLE_C10 >= (1 << LS_CNT_W)) begin
            $error("gtc_ctrl settle count exceeds counter width");
        end
    end

    gtc_pin_cfg_t pin_ff;
    logic [7:0] pos_code_ff;
    logic [7:0] neg_code_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] lshift_ff;
    logic [7:0] rdata_ff;
    logic [LS_CNT_W-1:0] ls_cnt_ff;
    gtc_ls_state_t ls_state_ff;
    gtc_ls_state_t nxt_ls_state;
    logic [LS_CNT_W-1:0] nxt_ls_cnt;
    logic [LS_CNT_W-1:0] settle_cnt;

    wire sel_connect = (addr_i == ADDR_PIN_CONNECT);
    wire sel_dir = (addr_i == ADDR_PIN_DIR);
    wire sel_value = (addr_i == ADDR_PIN_VALUE);
    wire sel_pos = (addr_i == ADDR_TEST_POS);
    wire sel_neg = (addr_i == ADDR_TEST_NEG);
    wire sel_ctrl = (addr_i == ADDR_TEST_CTRL);
    wire sel_ls = (addr_i == ADDR_LSHIFT);
    wire sel_stat = (addr_i == ADDR_STATUS);

    // Decode a code into its step and direction; unlisted codes act as mid.
    function automatic gtc_test_chan_t decode_code(input logic [7:0] c);
        gtc_test_chan_t r;
        r.code = c[4:0];
        r.raise = (c[7:5] == 3'h0) && (c[4:0] >= CODE_UP_MIN)
            && (c[4:0] <= CODE_UP_MAX);
        r.lower = (c[7:5] == 3'h0) && (c[4:0] >= CODE_DN_MIN)
            && (c[4:0] <= CODE_DN_MAX);
        r.valid = r.raise || r.lower || (c == {3'h0, CODE_MID});
        r.step = (r.raise || r.lower) ? c[3:0] : 4'h0;
        return r;
    endfunction

    // Step n on either side is the same offset, mirrored about mid supply.
    assign test_pos_o = decode_code(pos_code_ff);
    assign test_neg_o = decode_code(neg_code_ff);

    // Both channels are always offered to both converters' muxes.
    assign test_pos_to_mux_o = 1'b1;
    assign test_neg_to_mux_o = 1'b1;
    assign test_pos_pin_route_o = ctrl_ff[CTRL_POS_ROUTE_BIT];
    assign test_neg_pin_route_o = ctrl_ff[CTRL_NEG_ROUTE_BIT];

    // Pin i sits on analog input three plus i, pin 7 being the common pin.
    assign pin_connect_o = pin_ff.connect;
    assign pin_oe_o = pin_ff.connect & ~pin_ff.dir;
    assign pin_out_o = pin_ff.value & pin_oe_o;

    // Output pins read back zero rather than the level being driven.
    wire [7:0] value_rd = pin_in_i & pin_ff.connect
        & pin_ff.dir;

    assign level_shift_en_o = lshift_ff[0];
    assign level_shift_ready_o = (ls_state_ff == LS_READY);

    // Software may still start early; the ready flag only tells it when not to.
    wire chop_conflict = ctrl_ff[CTRL_CHOP_BIT]
        && (pos_code_ff != 8'h00 || neg_code_ff != 8'h00);
    wire [7:0] status_rd = {4'h0, chop_conflict,
        ~(test_pos_o.valid & test_neg_o.valid),
        (ls_state_ff == LS_SETTLING), level_shift_ready_o};

    wire [7:0] rd_mux =
        sel_connect ? pin_ff.connect :
        sel_dir ? pin_ff.dir :
        sel_value ? value_rd :
        sel_pos ? pos_code_ff :
        sel_neg ? neg_code_ff :
        sel_ctrl ? ctrl_ff :
        sel_ls ? lshift_ff :
        sel_stat ? status_rd : RD_UNMAPPED;

    assign settle_cnt =
        (lshift_ff[2:1] == LS_LOAD_C01) ? LS_CNT_W'(SETTLE_C01) :
        (lshift_ff[2:1] == LS_LOAD_C1) ? LS_CNT_W'(SETTLE_C1) :
        LS_CNT_W'(SETTLE_C10);

    wire ls_write = wr_i && sel_ls;

    // Settling timer restarts on every level-shift write with bit 0 set; a write with bit 0 clear turns it off.
    always_comb begin
        nxt_ls_state = ls_state_ff;
        nxt_ls_cnt = ls_cnt_ff;
        case (ls_state_ff)
            LS_OFF: begin
                if (ls_write && wdata_i[0]) begin
                    nxt_ls_state = LS_SETTLING;
                    nxt_ls_cnt = '0;
                end
            end
            LS_SETTLING: begin
                if (ls_write) begin
                    nxt_ls_state = wdata_i[0] ? LS_SETTLING : LS_OFF;
                    nxt_ls_cnt = '0;
                end else if (ls_cnt_ff + 1'b1 >= settle_cnt) begin
                    nxt_ls_state = LS_READY;
                end else begin
                    nxt_ls_cnt = ls_cnt_ff + 1'b1;
                end
            end
            LS_READY: begin
                if (ls_write) begin
                    nxt_ls_state = wdata_i[0] ? LS_SETTLING : LS_OFF;
                    nxt_ls_cnt = '0;
                end
            end
            default: begin
                nxt_ls_state = LS_OFF;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_ff.connect <= RST_PIN_CONNECT;
            pin_ff.dir <= RST_PIN_DIR;
            pin_ff.value <= RST_PIN_VALUE;
        end else if (clk_en_i && wr_i) begin
            if (sel_connect) begin
                pin_ff.connect <= wdata_i;
            end else if (sel_dir) begin
                pin_ff.dir <= wdata_i;
            end else if (sel_value) begin
                pin_ff.value <= wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pos_code_ff <= RST_TEST_CODE;
            neg_code_ff <= RST_TEST_CODE;
            ctrl_ff <= 8'h00;
            lshift_ff <= 8'h00;
        end else if (clk_en_i && wr_i) begin
            if (sel_pos) begin
                pos_code_ff <= wdata_i;
            end else if (sel_neg) begin
                neg_code_ff <= wdata_i;
            end else if (sel_ctrl) begin
                ctrl_ff <= {5'h00, wdata_i[2:0]};
            end else if (sel_ls) begin
                lshift_ff <= {5'h00, wdata_i[2:0]};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ls_state_ff <= LS_OFF;
            ls_cnt_ff <= '0;
            rdata_ff <= 8'h00;
        end else if (clk_en_i) begin
            ls_state_ff <= nxt_ls_state;
            ls_cnt_ff <= nxt_ls_cnt;
            if (rd_i) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    assign rdata_o = rdata_ff;
endmodule
`default_nettype wire

/* File: include/gtc_pkg.sv */
// Package with register map, field layout and code tables for the pin and test source control.
package gtc_pkg;
    localparam int NUM_PINS = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] ADDR_PIN_CONNECT = 4'h0;
    localparam logic [3:0] ADDR_PIN_DIR = 4'h1;
    localparam logic [3:0] ADDR_PIN_VALUE = 4'h2;
    localparam logic [3:0] ADDR_TEST_POS = 4'h3;
    localparam logic [3:0] ADDR_TEST_NEG = 4'h4;
    localparam logic [3:0] ADDR_TEST_CTRL = 4'h5;
    localparam logic [3:0] ADDR_LSHIFT = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [7:0] RST_PIN_CONNECT = 8'h00;
    localparam logic [7:0] RST_PIN_DIR = 8'hff;
    localparam logic [7:0] RST_PIN_VALUE = 8'h00;
    localparam logic [7:0] RST_TEST_CODE = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam int CTRL_POS_ROUTE_BIT = 0;
    localparam int CTRL_NEG_ROUTE_BIT = 1;
    localparam int CTRL_CHOP_BIT = 2;
    localparam int STAT_LS_READY_BIT = 0;
    localparam int STAT_LS_BUSY_BIT = 1;
    localparam int STAT_CODE_BAD_BIT = 2;
    localparam int STAT_CHOP_CONFLICT_BIT = 3;
    localparam logic [4:0] CODE_MID = 5'h00;
    localparam logic [4:0] CODE_UP_MIN = 5'h01;
    localparam logic [4:0] CODE_UP_MAX = 5'h09;
    localparam logic [4:0] CODE_DN_MIN = 5'h11;
    localparam logic [4:0] CODE_DN_MAX = 5'h19;
    localparam logic [3:0] SIGN_BIT_POS = 4'h4;
    localparam int LS_SETTLE_US_C01 = 220;
    localparam int LS_SETTLE_US_C1 = 2200;
    localparam int LS_SETTLE_US_C10 = 22000;
    localparam int CLK_MHZ = 100;
    localparam int LS_CYC_C01 = LS_SETTLE_US_C01 * CLK_MHZ;
    localparam int LS_CYC_C1 = LS_SETTLE_US_C1 * CLK_MHZ;
    localparam int LS_CYC_C10 = LS_SETTLE_US_C10 * CLK_MHZ;
    localparam int LS_CNT_W = 22;
    localparam logic [1:0] LS_LOAD_C01 = 2'h0;
    localparam logic [1:0] LS_LOAD_C1 = 2'h1;
    localparam logic [1:0] LS_LOAD_C10 = 2'h2;

    typedef enum logic [1:0] {
        LS_OFF = 2'b00,
        LS_SETTLING = 2'b01,
        LS_READY = 2'b11
    } gtc_ls_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] connect;
        logic [DATA_W-1:0] dir;
        logic [DATA_W-1:0] value;
    } gtc_pin_cfg_t;

    typedef struct packed {
        logic [4:0] code;
        logic valid;
        logic raise;
        logic lower;
        logic [3:0] step;
    } gtc_test_chan_t;
endpackage

/* File: sim/gtc_ctrl_properties.sv */
// Port-level assertions for the pin and test source control.
`timescale 1ns/100ps
`default_nettype none
module gtc_ctrl_properties
    import gtc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic [gtc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [gtc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [gtc_pkg::DATA_W-1:0] rdata_o,
    input wire logic [gtc_pkg::DATA_W-1:0] pin_in_i,
    input wire logic [gtc_pkg::DATA_W-1:0] pin_out_o,
    input wire logic [gtc_pkg::DATA_W-1:0] pin_oe_o,
    input wire logic [gtc_pkg::DATA_W-1:0] pin_connect_o,
    input wire gtc_pkg::gtc_test_chan_t test_pos_o,
    input wire gtc_pkg::gtc_test_chan_t test_neg_o,
    input wire logic test_pos_to_mux_o,
    input wire logic test_neg_to_mux_o,
    input wire logic test_pos_pin_route_o,
    input wire logic test_neg_pin_route_o,
    input wire logic level_shift_en_o,
    input wire logic level_shift_ready_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    wire logic wr_ok;
    wire logic rd_ok;
    assign wr_ok = wr_i & clk_en_i;
    assign rd_ok = rd_i & clk_en_i;
    chk_oe_connect: assert property ((pin_oe_o & ~pin_connect_o) == 8'h00)
        else $error("Pin driven without its function attached.");
    chk_out_gated: assert property ((pin_out_o & ~pin_oe_o) == 8'h00)
        else $error("Level shown on a pin that is not driven.");
    chk_conn_write: assert property (wr_ok && addr_i == ADDR_PIN_CONNECT
        |=> pin_connect_o == $past(wdata_i)) else $error("Connect write lost.");
    chk_value_read: assert property (rd_ok && addr_i == ADDR_PIN_VALUE
        |=> rdata_o == $past(pin_in_i & pin_connect_o & ~pin_oe_o))
        else $error("Pin value read wrong.");
    chk_pos_code: assert property (wr_ok && addr_i == ADDR_TEST_POS
        |=> test_pos_o.code == $past(wdata_i[4:0])) else $error("Positive code lost.");
    chk_neg_code: assert property (wr_ok && addr_i == ADDR_TEST_NEG
        |=> test_neg_o.code == $past(wdata_i[4:0])) else $error("Negative code lost.");
    chk_route_bits: assert property (wr_ok && addr_i == ADDR_TEST_CTRL
        |=> {test_neg_pin_route_o, test_pos_pin_route_o} == $past(wdata_i[1:0]))
        else $error("Route bits wrong.");
    chk_mid_level: assert property (test_pos_o.code == CODE_MID
        |-> !test_pos_o.raise && !test_pos_o.lower) else $error("Mid code offset.");
    chk_mux_offer: assert property (test_pos_to_mux_o && test_neg_to_mux_o)
        else $error("Test channel not offered to the muxes.");
    chk_reset_clear: assert property ($rose(nrst_i) |-> pin_connect_o == 8'h00)
        else $error("Connect bits not clear after reset.");
    chk_ls_ready: assert property (level_shift_ready_o |-> level_shift_en_o)
        else $error("Ready without level shift.");
    chk_ls_wait: assert property (wr_ok && addr_i == ADDR_LSHIFT && wdata_i[0]
        |=> !level_shift_ready_o [*2]) else $error("Level shift ready too soon.");
    chk_frozen_regs: assert property (!clk_en_i |=> $stable(pin_connect_o))
        else $error("State moved while the clock enable was low.");
    cov_value_read: cover property (rd_ok && addr_i == ADDR_PIN_VALUE);
    cov_route_both: cover property (test_pos_pin_route_o && test_neg_pin_route_o);
    cov_ls_ready: cover property ($rose(level_shift_ready_o));
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the pin and test source control.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import gtc_pkg::*;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] pin_in_i = 8'h00;
    logic [7:0] rdata_o, pin_out_o, pin_oe_o, pin_connect_o;
    gtc_test_chan_t test_pos_o, test_neg_o;
    logic pos_mux, neg_mux, pos_rt, neg_rt, ls_en, ls_rdy;
    int err_count = 0;
    int tests_run = 0;
    int seed = 32423;
    int n_cyc;
    logic [7:0] c, d, v, p, n;
    logic [7:0] exp_q[$];
    logic pend = 1'b0;
    always #5 mclk_i = ~mclk_i;
    gtc_ctrl #(.SETTLE_C01(5), .SETTLE_C1(10), .SETTLE_C10(20)) i_gtc_ctrl (
        .mclk_i, .nrst_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .pin_in_i, .pin_out_o, .pin_oe_o, .pin_connect_o,
        .test_pos_o, .test_neg_o, .test_pos_to_mux_o(pos_mux),
        .test_neg_to_mux_o(neg_mux), .test_pos_pin_route_o(pos_rt),
        .test_neg_pin_route_o(neg_rt), .level_shift_en_o(ls_en),
        .level_shift_ready_o(ls_rdy));
    task automatic cmp_port(input logic [15:0] act, input logic [15:0] exp);
        tests_run++;
        if (act !== exp) begin
            err_count++;
            $display("Error at %0t: port %h expected %h", $time, act, exp);
        end
    endtask
    task automatic cmp_rd(input logic [7:0] act, input logic [7:0] exp);
        tests_run++;
        if (act !== exp) begin
            err_count++;
            $display("Error at %0t: read %h expected %h", $time, act, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Checks run %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Strobes stay up between back-to-back cycles; each call drives both strobes again.
    task automatic wr(input logic [3:0] a, input logic [7:0] dt);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= dt;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        addr_i <= a;
        exp_q.push_back(e);
    endtask
    task automatic idle;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic ls_try(input logic [7:0] sel, input int lo, input int hi);
        wr(ADDR_LSHIFT, sel);
        idle();
        n_cyc = 0;
        while (ls_rdy !== 1'b1 && n_cyc < 40) begin
            @(negedge mclk_i);
            n_cyc++;
        end
        if (n_cyc == 40) begin
            err_count++;
        end
        cmp_port(16'(n_cyc >= lo && n_cyc <= hi), 16'h0001);
        cmp_port(16'(ls_en), 16'h0001);
    endtask
    always @(posedge mclk_i) pend <= rd_i & clk_en_i;
    always @(negedge mclk_i) begin
        if (pend) cmp_rd(rdata_o, exp_q.pop_front());
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 16; a++) rd(4'(a), (a == 1) ? 8'hff : 8'h00);
        idle();
        cmp_port({pin_oe_o, pin_connect_o}, 16'h0000);
        repeat (8) begin
            c = 8'($random(seed));
            d = 8'($random(seed));
            v = 8'($random(seed));
            p = 8'($random(seed));
            @(posedge mclk_i);
            pin_in_i <= p;
            wr(ADDR_PIN_CONNECT, c);
            wr(ADDR_PIN_DIR, d);
            wr(ADDR_PIN_VALUE, v);
            rd(ADDR_PIN_VALUE, p & c & d);
            rd(ADDR_PIN_DIR, d);
            idle();
            cmp_port({pin_oe_o, pin_out_o}, {c & ~d, v & c & ~d});
        end
        for (int k = 0; k < 10; k++) begin
            n = (k == 0) ? 8'h00 : (8'(k) | 8'h10);
            wr(ADDR_TEST_POS, 8'(k));
            wr(ADDR_TEST_NEG, n);
            rd(ADDR_TEST_NEG, n);
            idle();
            cmp_port(16'(test_pos_o), 16'({5'(k), 2'b11 & {1'b1, k != 0}, 1'b0, 4'(k)}));
            cmp_port(16'(test_neg_o), 16'({n[4:0], 2'b10, k != 0, 4'(k)}));
        end
        wr(ADDR_TEST_NEG, 8'h00);
        wr(ADDR_TEST_POS, 8'h13);
        idle();
        cmp_port(16'(test_pos_o), 16'h09d3);
        cmp_port(16'(test_neg_o), 16'h0040);
        wr(ADDR_TEST_POS, 8'h05);
        wr(ADDR_TEST_NEG, 8'h05);
        idle();
        cmp_port(16'(test_pos_o), 16'h02e5);
        cmp_port(16'(test_neg_o), 16'h02e5);
        wr(ADDR_TEST_POS, 8'h0a);
        rd(ADDR_STATUS, 8'h04);
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_TEST_CTRL, 8'(r));
            idle();
            cmp_port({pos_mux, neg_mux, neg_rt, pos_rt}, 16'(r) | 16'h000c);
        end
        wr(ADDR_TEST_CTRL, 8'hff);
        rd(ADDR_TEST_CTRL, 8'h07);
        rd(ADDR_STATUS, 8'h0c);
        ls_try(8'h01, 5, 5);
        ls_try(8'h03, 10, 10);
        ls_try(8'h07, 20, 20);
        ls_try(8'h05, 20, 20);
        rd(ADDR_STATUS, 8'h0d);
        wr(ADDR_LSHIFT, 8'h00);
        idle();
        cmp_port({ls_en, ls_rdy}, 16'h0000);
        @(posedge mclk_i);
        clk_en_i <= 1'b0;
        wr(ADDR_PIN_CONNECT, ~c);
        idle();
        cmp_port(16'(pin_connect_o), 16'(c));
        // A second reset in mid-run must drop connect bits set earlier.
        @(posedge mclk_i);
        clk_en_i <= 1'b1;
        nrst_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        cmp_port({pin_oe_o, pin_connect_o}, 16'h0000);
        @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (2) @(negedge mclk_i);
        cmp_port({pin_out_o, 6'h00, ls_en, ls_rdy}, 16'h0000);
        print_verdict();
    end
endmodule
bind gtc_ctrl gtc_ctrl_properties i_gtc_ctrl_properties (.mclk_i, .nrst_i,
    .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_in_i,
    .pin_out_o, .pin_oe_o, .pin_connect_o, .test_pos_o, .test_neg_o,
    .test_pos_to_mux_o, .test_neg_to_mux_o, .test_pos_pin_route_o,
    .test_neg_pin_route_o, .level_shift_en_o, .level_shift_ready_o);
`default_nettype wire
